// ==== core/bms_boot_mode_selector.sv ====
// Boot mode selector top with APB register slave
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module bms_boot_mode_selector (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic probe_attached,
    input wire logic [255:0] gpio_in,
    input wire logic [31:0] otp_pin_select_config,
    input wire logic [63:0] otp_default_table,
    output logic [21:0] pc_load,
    output logic pc_load_valid,
    output logic irq_expansion_block_en,
    output logic global_irq_mask_en,
    output bms_pkg::bms_result_t boot_result
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers, three stages, change accepted when 2 and 3 agree
    logic [255:0] gp1_q, gp2_q, gp3_q, gp_q;
    logic [2:0] prb_q;
    logic prb_f_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp1_q <= '0;
            gp2_q <= '0;
            gp3_q <= '0;
            prb_q <= 3'h0;
        end else begin
            gp1_q <= gpio_in;
            gp2_q <= gp1_q;
            gp3_q <= gp2_q;
            prb_q <= {prb_q[1:0], probe_attached};
        end
    end

    // Filtered pin levels, per bit
    genvar gi;
    generate
        for (gi = 0; gi < bms_pkg::BMS_NPINS; gi++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gp_q[gi] <= 1'b0;
                end else if (gp2_q[gi] == gp3_q[gi]) begin
                    gp_q[gi] <= gp3_q[gi];
                end
            end
        end
    endgenerate

    // Filtered probe presence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prb_f_q <= 1'b0;
        end else if (prb_q[1] == prb_q[2]) begin
            prb_f_q <= prb_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug registers held in irq-vector RAM; a reset of this block clears
    // them, so a debugger rewrites them and restarts via ctrl (soft reset)
    logic [31:0] dbg_cfg_q;
    logic [63:0] dbg_tbl_q;
    logic restart_q;

    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic hit_cfg = paddr == bms_pkg::BMS_OFF_DBG_CFG;
    wire logic hit_tlo = paddr == bms_pkg::BMS_OFF_DBG_TLO;
    wire logic hit_thi = paddr == bms_pkg::BMS_OFF_DBG_THI;
    wire logic hit_st = paddr == bms_pkg::BMS_OFF_STATUS;
    wire logic hit_res = paddr == bms_pkg::BMS_OFF_RESULT;
    wire logic hit_ctl = paddr == bms_pkg::BMS_OFF_CTRL;
    wire logic hit_any = hit_cfg || hit_tlo || hit_thi || hit_st ||
        hit_res || hit_ctl;

    // Debugger writes of configuration and table
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_cfg_q <= 32'h0000_0000;
            dbg_tbl_q <= 64'h0;
        end else begin
            if (wr && hit_cfg) dbg_cfg_q <= pwdata;
            if (wr && hit_tlo) dbg_tbl_q[31:0] <= pwdata;
            if (wr && hit_thi) dbg_tbl_q[63:32] <= pwdata;
        end
    end

    // Ctrl bit 0 write restarts selection, as a reset would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr && hit_ctl && pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection for the chosen flow
    bms_pkg::bms_state_t st_q;
    logic use_dbg_q, use_pins_q;
    logic [2:0] idx_q;
    logic [2:0] nact_q;
    bms_pkg::bms_result_t res_q;
    logic [1:0] vec_cnt_q;

    // Last count of the vector fetch, filters are settled after it
    wire logic [1:0] vec_last = 2'(bms_pkg::BMS_VEC_CYC - 1);

    wire logic [7:0] dbg_key = dbg_cfg_q[31:bms_pkg::BMS_KEY_LSB];
    wire logic [7:0] otp_key =
        otp_pin_select_config[31:bms_pkg::BMS_KEY_LSB];
    wire logic dbg_key_ok = dbg_key == bms_pkg::BMS_KEY_NATIVE ||
        dbg_key == bms_pkg::BMS_KEY_EMULATE;
    wire logic dbg_native = dbg_key == bms_pkg::BMS_KEY_NATIVE;
    wire logic otp_key_ok = otp_key == bms_pkg::BMS_KEY_NATIVE;
    wire logic [31:0] cfg_sel =
        use_dbg_q ? dbg_cfg_q : otp_pin_select_config;
    wire logic [63:0] tbl_sel =
        use_dbg_q ? dbg_tbl_q : otp_default_table;

    // Index build: active fields packed upward from bit 0
    logic [2:0] idx_c;
    logic [2:0] nact_c;
    always_comb begin
        logic [7:0] fld;
        fld = 8'h00;
        idx_c = 3'h0;
        nact_c = 3'h0;
        for (int f = 0; f < bms_pkg::BMS_NFIELDS; f++) begin
            fld = cfg_sel[f*bms_pkg::BMS_FIELD_W +: bms_pkg::BMS_FIELD_W];
            if (fld != bms_pkg::BMS_FIELD_UNUSED) begin
                idx_c[nact_c[1:0]] = use_dbg_q ? 1'b0 : gp_q[fld];
                nact_c = nact_c + 3'h1;
            end
        end
    end

    // Debug fields are selections, not pins: field value bit 0 is the bit
    wire logic [2:0] dbg_idx_c;
    logic [2:0] dbg_idx_r;
    always_comb begin
        logic [1:0] n;
        logic [7:0] fld;
        n = 2'h0;
        fld = 8'h00;
        dbg_idx_r = 3'h0;
        for (int f = 0; f < bms_pkg::BMS_NFIELDS; f++) begin
            fld = dbg_cfg_q[f*bms_pkg::BMS_FIELD_W +: bms_pkg::BMS_FIELD_W];
            if (fld != bms_pkg::BMS_FIELD_UNUSED) begin
                dbg_idx_r[n] = fld[0];
                n = n + 2'h1;
            end
        end
    end
    assign dbg_idx_c = dbg_idx_r;

    // Index masked to the reachable entries
    wire logic [2:0] idx_raw = use_dbg_q ? dbg_idx_c : idx_c;
    wire logic [2:0] idx_mask = 3'(({3'h0, 1'b1} << nact_c) - 4'h1);
    wire logic [2:0] idx_eff = idx_raw & idx_mask;

    // Two default pins decode to four modes
    wire logic [1:0] def_pins = {gp_q[bms_pkg::BMS_PIN_DEF_B],
        gp_q[bms_pkg::BMS_PIN_DEF_A]};
    wire logic [7:0] def_entry =
        def_pins == 2'h0 ? bms_pkg::BMS_DEF_PARALLEL :
        def_pins == 2'h1 ? bms_pkg::BMS_DEF_SERIAL :
        def_pins == 2'h2 ? bms_pkg::BMS_DEF_CAN :
        bms_pkg::BMS_DEF_FLASH;

    // Table entry chosen by the index
    wire logic [7:0] tbl_entry =
        tbl_sel[idx_q*bms_pkg::BMS_ENTRY_W +: bms_pkg::BMS_ENTRY_W];
    wire logic [7:0] entry = use_pins_q ? tbl_entry : def_entry;

    ////////////////////////////////////////////////////////////////////////
    // Selection sequencer, restarts from vector fetch on every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= bms_pkg::BMS_S_VECTOR;
            use_dbg_q <= 1'b0;
            use_pins_q <= 1'b0;
            idx_q <= 3'h0;
            nact_q <= 3'h0;
            res_q <= '0;
            vec_cnt_q <= 2'h0;
        end else if (restart_q) begin
            st_q <= bms_pkg::BMS_S_VECTOR;
            res_q <= '0;
            vec_cnt_q <= 2'h0;
        end else begin
            case (st_q)
                bms_pkg::BMS_S_VECTOR: begin
                    if (vec_cnt_q == vec_last) begin
                        st_q <= bms_pkg::BMS_S_FLOW;
                    end else begin
                        vec_cnt_q <= vec_cnt_q + 2'h1;
                    end
                end
                bms_pkg::BMS_S_FLOW: begin
                    if (prb_f_q) begin
                        if (!dbg_key_ok) begin
                            st_q <= bms_pkg::BMS_S_WAIT;
                        end else begin
                            use_dbg_q <= dbg_native;
                            use_pins_q <= dbg_native || otp_key_ok;
                            st_q <= bms_pkg::BMS_S_INDEX;
                        end
                    end else begin
                        use_dbg_q <= 1'b0;
                        use_pins_q <= otp_key_ok;
                        st_q <= bms_pkg::BMS_S_INDEX;
                    end
                end
                bms_pkg::BMS_S_INDEX: begin
                    idx_q <= idx_eff;
                    nact_q <= nact_c;
                    st_q <= bms_pkg::BMS_S_PICK;
                end
                bms_pkg::BMS_S_PICK: begin
                    res_q.valid <= 1'b1;
                    res_q.mode <= entry[bms_pkg::BMS_MODE_W-1:0];
                    res_q.options <=
                        entry[bms_pkg::BMS_ENTRY_W-1:bms_pkg::BMS_MODE_W];
                    res_q.index <= use_pins_q ? idx_q : {1'b0, def_pins};
                    st_q <= bms_pkg::BMS_S_DONE;
                end
                bms_pkg::BMS_S_WAIT: begin
                    res_q.wait_mode <= 1'b1;
                end
                default: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the core
    wire logic in_sel = st_q != bms_pkg::BMS_S_DONE;
    assign irq_expansion_block_en = !in_sel;
    assign global_irq_mask_en = !in_sel;
    assign pc_load = bms_pkg::BMS_RESET_VECTOR;
    assign pc_load_valid = st_q == bms_pkg::BMS_S_VECTOR;
    assign boot_result = res_q;

    ////////////////////////////////////////////////////////////////////////
    // APB read path, zero wait states
    wire logic [31:0] status_w = {21'h0, idx_q, 2'h0,
        in_sel, use_pins_q, use_dbg_q, prb_f_q,
        res_q.wait_mode, res_q.valid};
    wire logic [31:0] result_w = {17'h0, res_q.index, res_q.options,
        res_q.mode, 1'b0, nact_q};
    wire logic [31:0] rd_w =
        hit_cfg ? dbg_cfg_q :
        hit_tlo ? dbg_tbl_q[31:0] :
        hit_thi ? dbg_tbl_q[63:32] :
        hit_st ? status_w :
        hit_res ? result_w : 32'h0;

    // Read data registered at the edge that ends the setup phase, ready in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_w;
        end
    end

    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;

endmodule // bms_boot_mode_selector

// ==== core/bms_pkg.sv ====
// Constants, types and register map of the boot mode selector
package bms_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] BMS_OFF_DBG_CFG = 8'h00;
    localparam logic [7:0] BMS_OFF_DBG_TLO = 8'h04;
    localparam logic [7:0] BMS_OFF_DBG_THI = 8'h08;
    localparam logic [7:0] BMS_OFF_STATUS = 8'h0C;
    localparam logic [7:0] BMS_OFF_RESULT = 8'h10;
    localparam logic [7:0] BMS_OFF_CTRL = 8'h14;

    // Boot vector and keys
    localparam logic [21:0] BMS_RESET_VECTOR = 22'h3FFFC0;
    localparam logic [7:0] BMS_KEY_NATIVE = 8'h5A;
    localparam logic [7:0] BMS_KEY_EMULATE = 8'hA5;
    localparam logic [7:0] BMS_FIELD_UNUSED = 8'hFF;

    // Field layout of a pin select configuration word
    localparam int BMS_KEY_LSB = 24;
    localparam int BMS_FIELD_W = 8;
    localparam int BMS_NFIELDS = 3;
    localparam int BMS_NPINS = 256;
    localparam int BMS_ENTRY_W = 8;
    localparam int BMS_MODE_W = 4;
    localparam int BMS_NENTRY = 8;

    // Default select pin numbers and vector fetch length; the fetch lasts
    // long enough for the probe and pin filters to settle after a reset
    localparam int BMS_PIN_DEF_A = 24;
    localparam int BMS_PIN_DEF_B = 32;
    localparam int BMS_VEC_CYC = 4;

    // Default pin decode results, low nibble of an entry
    localparam logic [7:0] BMS_DEF_PARALLEL = 8'h00;
    localparam logic [7:0] BMS_DEF_SERIAL = 8'h01;
    localparam logic [7:0] BMS_DEF_CAN = 8'h02;
    localparam logic [7:0] BMS_DEF_FLASH = 8'h03;

    // Status bit positions
    localparam int BMS_ST_DONE = 0;
    localparam int BMS_ST_WAIT = 1;
    localparam int BMS_ST_DEBUG = 2;
    localparam int BMS_ST_OTP = 3;
    localparam int BMS_ST_PINS = 4;
    localparam int BMS_ST_IRQ_OFF = 5;
    localparam int BMS_ST_IDX = 8;

    // Selection sequencer states
    typedef enum logic [2:0] {
        BMS_S_VECTOR = 3'b000,
        BMS_S_FLOW = 3'b001,
        BMS_S_INDEX = 3'b010,
        BMS_S_PICK = 3'b011,
        BMS_S_DONE = 3'b100,
        BMS_S_WAIT = 3'b101
    } bms_state_t;

    // Boot decision handed to the boot init routine
    typedef struct packed {
        logic valid;
        logic wait_mode;
        logic [3:0] mode;
        logic [3:0] options;
        logic [2:0] index;
    } bms_result_t;

endpackage

// ==== testbench/bms_sva.sv ====
// Port checker of the boot mode selector
`timescale 1ns/100ps
module bms_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [21:0] pc_load,
    input wire logic pc_load_valid,
    input wire logic irq_expansion_block_en,
    input wire logic global_irq_mask_en,
    input wire bms_pkg::bms_result_t boot_result
);
    default clocking dck @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // Access phase and restart write decode
    wire acc = psel && penable;
    wire ctrl_wr = acc && pwrite && paddr == 8'h14;
    // Steps of a selection run
    sequence s_vec_leave;
        pc_load_valid ##1 !pc_load_valid;
    endsequence
    sequence s_settled;
        boot_result.valid || boot_result.wait_mode;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_pc_vector: assert property (pc_load_valid |-> pc_load == 22'h3FFFC0)
        else $error("pc_load is not the reset vector");
    a_irq_select: assert property (pc_load_valid |-> !irq_expansion_block_en)
        else $error("irq block enabled during vector fetch");
    a_irq_pair: assert property (irq_expansion_block_en == global_irq_mask_en)
        else $error("irq block and global mask disagree");
    a_ready_now: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && paddr > 8'h14 |-> pslverr)
        else $error("no pslverr on unmapped address");
    a_result_time: assert property (s_vec_leave |-> ##[0:4] s_settled)
        else $error("selection did not settle in time");
    a_wait_irq: assert property (boot_result.wait_mode |-> !global_irq_mask_en)
        else $error("interrupts enabled in wait mode");
    a_wait_holds: assert property (boot_result.wait_mode && !pc_load_valid
        && !ctrl_wr && !$past(ctrl_wr) |=> boot_result.wait_mode)
        else $error("wait mode left without restart");
endmodule // bms_sva

bind bms_boot_mode_selector bms_sva chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pready, .pslverr, .pc_load, .pc_load_valid,
    .irq_expansion_block_en, .global_irq_mask_en, .boot_result);

// ==== testbench/bms_pins_model.sv ====
// Model of the debug probe and boot select pins outside the selector
`timescale 1ns/100ps
module bms_pins_model (
    input wire logic pclk,
    input wire logic probe_on,
    input wire logic [9:0] pin_lvl,
    input wire logic [31:0] otp_cfg,
    input wire logic [63:0] otp_tbl,
    output logic probe_attached,
    output logic [255:0] gpio_in,
    output logic [31:0] otp_pin_select_config,
    output logic [63:0] otp_default_table
);
    logic flip_q;
    // Unselected pins wander every cycle so stale levels are never trusted
    initial flip_q = 1'h0;
    always @(posedge pclk) flip_q <= !flip_q;
    // Pins 0-7 as chosen, default select pins at 24 and 32
    always_comb begin
        gpio_in = {256{flip_q}};
        gpio_in[7:0] = pin_lvl[7:0];
        gpio_in[24] = pin_lvl[8];
        gpio_in[32] = pin_lvl[9];
    end
    // Probe presence and one-time-programmable words
    assign probe_attached = probe_on;
    assign otp_pin_select_config = otp_cfg;
    assign otp_default_table = otp_tbl;
endmodule // bms_pins_model

// ==== testbench/tb.sv ====
// Self-checking bench of the boot mode selector
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic probe;
        logic [9:0] pins;
        logic [31:0] dcfg;
        logic [31:0] ocfg;
        logic wt;
        logic full;
        logic [3:0] mode;
        logic [3:0] opt;
        logic [2:0] idx;
    } bms_row_t;
    // Table entry i: OTP gives mode i, debug gives mode 8+i
    localparam logic [63:0] OT = 64'hF7E6D5C4B3A29180;
    localparam logic [63:0] DT = 64'h1F2E3D4C5B6A7988;
    logic pclk, presetn, psel, penable, pwrite, probe_on, pready, pslverr, e;
    logic probe_attached, pc_load_valid, irq_en, mask_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, otp_cfg, otp_pin_select_config, q;
    logic [9:0] pin_lvl;
    logic [21:0] pc_load;
    logic [255:0] gpio_in;
    logic [63:0] otp_default_table;
    bms_pkg::bms_result_t boot_result;
    int error_cnt = 0;
    int n_compared = 0;
    bms_row_t rows[12] = '{
        '{1'h0, 10'h000, 32'h0, 32'hA5020100, 1'h0, 1'h0, 4'h0, 4'h0, 3'h0},
        '{1'h0, 10'h100, 32'h0, 32'hA5020100, 1'h0, 1'h0, 4'h1, 4'h0, 3'h0},
        '{1'h0, 10'h200, 32'h0, 32'hA5020100, 1'h0, 1'h0, 4'h2, 4'h0, 3'h0},
        '{1'h0, 10'h300, 32'h0, 32'hA5020100, 1'h0, 1'h0, 4'h3, 4'h0, 3'h0},
        '{1'h0, 10'h020, 32'h0, 32'h5A07FF05, 1'h0, 1'h1, 4'h1, 4'h9, 3'h1},
        '{1'h0, 10'h0FF, 32'h0, 32'h5AFFFFFF, 1'h0, 1'h1, 4'h0, 4'h8, 3'h0},
        '{1'h0, 10'h00E, 32'h0, 32'h5A030201, 1'h0, 1'h1, 4'h7, 4'hF, 3'h7},
        '{1'h1, 10'h00E, 32'h33000000, 32'h0, 1'h1, 1'h0, 4'h0, 4'h0, 3'h0},
        '{1'h1, 10'h00E, 32'h5A0001FF, 32'h5A030201, 1'h0, 1'h1, 4'h9, 4'h7, 3'h1},
        '{1'h1, 10'h020, 32'hA5000000, 32'h5A07FF05, 1'h0, 1'h1, 4'h1, 4'h9, 3'h1},
        '{1'h1, 10'h000, 32'h5A010101, 32'h0, 1'h0, 1'h1, 4'hF, 4'h1, 3'h7},
        '{1'h1, 10'h300, 32'hA5000000, 32'h0, 1'h0, 1'h0, 4'h3, 4'h0, 3'h0}
    };
    ////////////////////////////////////////////////////////////////////////
    bms_pins_model pins_u (.pclk, .probe_on, .pin_lvl, .otp_cfg, .otp_tbl(OT),
        .probe_attached, .gpio_in, .otp_pin_select_config, .otp_default_table);
    bms_boot_mode_selector dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .probe_attached, .gpio_in,
        .otp_pin_select_config, .otp_default_table, .pc_load, .pc_load_valid,
        .irq_expansion_block_en(irq_en), .global_irq_mask_en(mask_en),
        .boot_result);
    // Clock of 5 ns
    always #2.5 pclk = !pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer; read data and error land in q and e
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // Access phase held until pready is seen high at an edge
        while (pready !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'h1) error_cnt++;
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Load debug words, restart and let the selection settle
    task automatic rerun(input logic [31:0] dc);
        apb(1'h1, 8'h00, dc);
        apb(1'h1, 8'h04, DT[31:0]);
        apb(1'h1, 8'h08, DT[63:32]);
        apb(1'h1, 8'h14, 32'h1);
        for (int n = 0; n < 10 && pc_load_valid !== 1'h1; n++) @(posedge pclk);
        chk("pc_vector", 32'h1, pc_load_valid);
        // Vector fetch of four cycles, then flow, index, pick and done, or flow and wait
        repeat (10) @(posedge pclk);
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #50000;
        error_cnt++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        {psel, penable, pwrite, probe_on} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_lvl = 10'h000;
        otp_cfg = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        foreach (rows[i]) begin
            probe_on <= rows[i].probe;
            pin_lvl <= rows[i].pins;
            otp_cfg <= rows[i].ocfg;
            repeat (5) @(posedge pclk);
            rerun(rows[i].dcfg);
            chk("wait_mode", rows[i].wt, boot_result.wait_mode);
            chk("irq_done", rows[i].wt ? 32'h0 : 32'h3, {irq_en, mask_en});
            if (!rows[i].wt) begin
                chk("valid", 32'h1, boot_result.valid);
                chk("mode", rows[i].mode, boot_result.mode);
            end
            if (rows[i].full) begin
                chk("options", rows[i].opt, boot_result.options);
                chk("index", rows[i].idx, boot_result.index);
            end
        end
        // Second reset in mid-run, probe attached, debug words cleared
        repeat (5) @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        chk("pc_load_valid", 32'h1, pc_load_valid);
        chk("pc_load", 32'h3FFFC0, pc_load);
        chk("irq_enables", 32'h0, {irq_en, mask_en});
        chk("result", 32'h0, boot_result);
        presetn <= 1'h1;
        repeat (30) @(posedge pclk);
        apb(1'h0, 8'h00, 32'h0);
        chk("dbg_cfg", 32'h0, q);
        apb(1'h1, 8'h04, 32'h11223344);
        apb(1'h1, 8'h08, 32'h55667788);
        apb(1'h0, 8'h04, 32'h0);
        chk("tbl_lo", 32'h11223344, q);
        apb(1'h0, 8'h08, 32'h0);
        chk("tbl_hi", 32'h55667788, q);
        chk("wait_held", 32'h1, boot_result.wait_mode);
        chk("irq_in_wait", 32'h0, {irq_en, mask_en});
        apb(1'h1, 8'h40, 32'h1);
        chk("wr_err", 32'h1, e);
        apb(1'h0, 8'h40, 32'h0);
        chk("rd_err", 32'h1, e);
        chk("rd_data", 32'h0, q);
        wrap_up();
    end
endmodule // tb
